// [inc/bridge_pkg.sv]
// shared constants for the bridge primary-side ends
package bridge_pkg;
	localparam int          CFG_AW           = 8;
	localparam int          HOST_AW          = 9;
	localparam logic [7:0]  SUBSYS_VENDOR    = 8'h40;
	localparam logic [7:0]  SUBSYS           = 8'h42;
	localparam logic [7:0]  SYS_CTRL         = 8'h80;
	localparam logic [7:0]  MF_ROUTING       = 8'h8c;
	localparam logic [7:0]  BRIDGE_STATUS    = 8'h90;
	localparam int          WP_BIT           = 5;
	localparam logic [31:0] SYS_CTRL_RESET   = 32'h0000_0020;
	localparam logic [31:0] MF_ROUTING_RESET = 32'h0000_0000;
	localparam int          MF_LOCK_LSB      = 16;
	localparam int          MF_LOCK_MSB      = 19;
	localparam logic [3:0]  MF_LOCK_SEL      = 4'h2;
	localparam int          LOCK_GRAIN_BITS  = 4;
	localparam int          EE_BITS          = 32;
	localparam int          EE_HALF_CYCLES   = 5;
	localparam int          CLK_MHZ          = 10;
	localparam int          HOLD_WAIT_US     = 100;
	localparam int          HOLD_WAIT_CYCLES = HOLD_WAIT_US * CLK_MHZ;
	localparam int          PRIM_LAG_CYCLES  = 16;
	localparam logic [8:0]  HOST_CTRL        = 9'h100;
	localparam logic [8:0]  HOST_STATUS      = 9'h104;
	localparam int          CTRL_SUSPEND_BIT = 0;
	localparam int          CTRL_LOCK_BIT    = 1;
	localparam int          HOST_LOCAL_BIT   = 8;
endpackage

// [inc/bridge_link.sv]
// primary-side link between host and bridge device
interface bridge_link;
	logic        global_reset_n;
	logic        primary_bus_reset_n;
	logic        suspend;
	logic [7:0]  cfg_addr;
	logic [31:0] cfg_wdata;
	logic        cfg_write;
	logic        cfg_read;
	logic [31:0] cfg_rdata;
	logic        txn_valid;
	logic [31:0] txn_addr;
	logic        txn_write;
	logic        lock_n;
	logic        txn_retry;
	logic        post_enable;
	logic        inta_out;
	logic        inta_oe_n;
	logic        inta_n;
	// open-drain wire: released line reads high
	assign inta_n = inta_oe_n ? 1'b1 : inta_out;
	modport device (
		input  global_reset_n, primary_bus_reset_n, suspend,
		input  cfg_addr, cfg_wdata, cfg_write, cfg_read,
		input  txn_valid, txn_addr, txn_write, lock_n,
		output cfg_rdata, txn_retry, post_enable, inta_out, inta_oe_n
	);
	modport host (
		output global_reset_n, primary_bus_reset_n, suspend,
		output cfg_addr, cfg_wdata, cfg_write, cfg_read,
		output txn_valid, txn_addr, txn_write, lock_n,
		input  cfg_rdata, txn_retry, post_enable, inta_n
	);
endinterface

// [rtl/bridge_device.sv]
// bridge device end: subsystem ids, lock tracking, eeprom load
module bridge_device (
	// clock and reset
	input  wire logic                 CLK,
	input  wire logic                 ARST_N,
	// primary link
	bridge_link.device                LINK,
	// multipurpose pin four
	output logic                      MULTIPURPOSE_PIN_FOUR,
	output logic                      MULTIPURPOSE_PIN_FOUR_OE_N,
	// card side lock
	output logic                      CARD_LOCK_N,
	output logic                      CARD_LOCK_OE_N,
	// serial eeprom
	output logic                      EE_SCL,
	output logic                      EE_SCL_OE_N,
	input  wire logic                 EE_SDA_IN,
	// card interrupt
	input  wire logic                 CARD_IRQ_N,
	// forwarded transaction
	output logic                      FWD_VALID,
	output logic [31:0]               FWD_ADDR,
	output logic                      FWD_WRITE,
	output logic                      FWD_POSTED,
	output logic                      LOAD_DONE
);
	import bridge_pkg::*;

	typedef enum {LD_SHIFT, LD_DONE} load_t;

	function automatic logic same_word(input logic [7:0] a, input logic [7:0] b);
		same_word = (a[7:2] == b[7:2]);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// reset gating
	logic global_active;
	logic core_rst;
	assign global_active = !LINK.global_reset_n;
	// suspend keeps primary reset away from all core state
	assign core_rst = global_active || (!LINK.primary_bus_reset_n && !LINK.suspend);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers: sda in bit 0, card interrupt in bit 1
	logic [1:0] s1, s2, s3, pin_stable;
	logic [1:0] next_pin_stable;
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			next_pin_stable[i] = (s2[i] == s3[i]) ? s3[i] : pin_stable[i];
		end
	end
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			s1         <= 2'h3;
			s2         <= 2'h3;
			s3         <= 2'h3;
			pin_stable <= 2'h3;
		end else begin
			s1         <= {CARD_IRQ_N, EE_SDA_IN};
			s2         <= s1;
			s3         <= s2;
			pin_stable <= next_pin_stable;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// eeprom loader and configuration registers
	load_t       ld_state, next_ld_state;
	logic [7:0]  div, next_div;
	logic [5:0]  bit_cnt, next_bit_cnt;
	logic [31:0] shift, next_shift;
	logic        scl, next_scl;
	logic [15:0] svid, next_svid;
	logic [15:0] sid, next_sid;
	logic [31:0] sys_ctrl, next_sys_ctrl;
	logic [31:0] mf_routing, next_mf_routing;
	logic [31:0] rdata, next_rdata;
	logic        locked, next_locked;
	logic [27:0] lock_region, next_lock_region;
	logic        acquire, retry;

	always_comb begin
		next_ld_state   = ld_state;
		next_div        = div;
		next_bit_cnt    = bit_cnt;
		next_shift      = shift;
		next_scl        = scl;
		next_svid       = svid;
		next_sid        = sid;
		next_sys_ctrl   = sys_ctrl;
		next_mf_routing = mf_routing;
		if (core_rst) begin
			// each global reset, or primary reset without suspend, restarts the id load
			next_ld_state   = LD_SHIFT;
			next_div        = 8'h00;
			next_bit_cnt    = 6'h00;
			next_scl        = 1'b0;
			next_sys_ctrl   = SYS_CTRL_RESET;
			next_mf_routing = MF_ROUTING_RESET;
		end else begin
			case (ld_state)
				LD_SHIFT: begin
					if (div == 8'(EE_HALF_CYCLES - 1)) begin
						next_div = 8'h00;
						next_scl = !scl;
						if (!scl) begin
							next_shift   = {shift[30:0], pin_stable[0]};
							next_bit_cnt = bit_cnt + 6'h01;
							if (bit_cnt == 6'(EE_BITS - 1)) begin
								// vendor id in the low half, subsystem_ident above
								next_svid     = next_shift[15:0];
								next_sid      = next_shift[31:16];
								next_ld_state = LD_DONE;
							end
						end
					end else begin
						next_div = div + 8'h01;
					end
				end
				LD_DONE: begin
					next_scl = 1'b0;
				end
				default: next_ld_state = LD_DONE;
			endcase
			if (LINK.cfg_write) begin
				// id writes while loading are dropped: the loader owns the ids
				if (same_word(LINK.cfg_addr, SUBSYS_VENDOR)) begin
					if (!sys_ctrl[WP_BIT] && ld_state == LD_DONE) begin
						next_svid = LINK.cfg_wdata[15:0];
						next_sid  = LINK.cfg_wdata[31:16];
					end
				end else if (same_word(LINK.cfg_addr, SYS_CTRL)) begin
					next_sys_ctrl = LINK.cfg_wdata;
				end else if (same_word(LINK.cfg_addr, MF_ROUTING)) begin
					next_mf_routing = LINK.cfg_wdata;
				end
			end
		end
		next_rdata = 32'h0000_0000;
		if (LINK.cfg_read) begin
			if (same_word(LINK.cfg_addr, SUBSYS_VENDOR)) begin
				next_rdata = {sid, svid};
			end else if (same_word(LINK.cfg_addr, SYS_CTRL)) begin
				next_rdata = sys_ctrl;
			end else if (same_word(LINK.cfg_addr, MF_ROUTING)) begin
				next_rdata = mf_routing;
			end else if (same_word(LINK.cfg_addr, BRIDGE_STATUS)) begin
				next_rdata = {30'h0, ld_state == LD_DONE, locked};
			end
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ld_state   <= LD_SHIFT;
			div        <= 8'h00;
			bit_cnt    <= 6'h00;
			shift      <= 32'h0000_0000;
			scl        <= 1'b0;
			svid       <= 16'h0000;
			sid        <= 16'h0000;
			sys_ctrl   <= SYS_CTRL_RESET;
			mf_routing <= MF_ROUTING_RESET;
			rdata      <= 32'h0000_0000;
		end else begin
			ld_state   <= next_ld_state;
			div        <= next_div;
			bit_cnt    <= next_bit_cnt;
			shift      <= next_shift;
			scl        <= next_scl;
			svid       <= next_svid;
			sid        <= next_sid;
			sys_ctrl   <= next_sys_ctrl;
			mf_routing <= next_mf_routing;
			rdata      <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// lock tracking and forwarding toward the card
	logic        fwd_valid, next_fwd_valid;
	logic [31:0] fwd_addr, next_fwd_addr;
	logic        fwd_write, next_fwd_write;
	logic        fwd_posted, next_fwd_posted;
	logic        mf_out, next_mf_out;

	// a grant alone never takes the lock; only lock_n low on a transaction does
	assign acquire = LINK.txn_valid && !LINK.lock_n && !locked;
	// only the 16-byte aligned locked region refuses non-owners
	assign retry = LINK.txn_valid && locked && LINK.lock_n
		&& (LINK.txn_addr[31:LOCK_GRAIN_BITS] == lock_region);

	always_comb begin
		next_locked      = locked;
		next_lock_region = lock_region;
		if (core_rst) begin
			next_locked = 1'b0;
		end else if (acquire) begin
			next_locked      = 1'b1;
			next_lock_region = LINK.txn_addr[31:LOCK_GRAIN_BITS];
		end else if (locked && LINK.lock_n && !LINK.txn_valid) begin
			next_locked = 1'b0;
		end
		next_fwd_valid  = LINK.txn_valid && !retry && !core_rst;
		next_fwd_addr   = LINK.txn_addr;
		next_fwd_write  = LINK.txn_write;
		// a write under lock is never posted
		next_fwd_posted = LINK.txn_write && !(locked || acquire);
		next_mf_out     = !(locked || acquire) && LINK.lock_n;
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			locked      <= 1'b0;
			lock_region <= 28'h0;
			fwd_valid   <= 1'b0;
			fwd_addr    <= 32'h0000_0000;
			fwd_write   <= 1'b0;
			fwd_posted  <= 1'b0;
			mf_out      <= 1'b1;
		end else begin
			locked      <= next_locked;
			lock_region <= next_lock_region;
			fwd_valid   <= next_fwd_valid;
			fwd_addr    <= next_fwd_addr;
			fwd_write   <= next_fwd_write;
			fwd_posted  <= next_fwd_posted;
			mf_out      <= next_mf_out;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs; every enable is released during global reset
	assign LINK.cfg_rdata   = rdata;
	assign LINK.txn_retry   = retry;
	assign LINK.post_enable = !locked;
	// interrupt a is open drain on the primary side
	assign LINK.inta_out    = 1'b0;
	assign LINK.inta_oe_n   = global_active || pin_stable[1];
	// lock shows on pin four only when routing selects it
	assign MULTIPURPOSE_PIN_FOUR      = mf_out;
	assign MULTIPURPOSE_PIN_FOUR_OE_N = global_active
		|| (mf_routing[MF_LOCK_MSB:MF_LOCK_LSB] != MF_LOCK_SEL);
	// card lock is driven outward only: card-initiated locks are not honoured
	assign CARD_LOCK_N    = !locked;
	assign CARD_LOCK_OE_N = global_active;
	assign EE_SCL         = scl;
	assign EE_SCL_OE_N    = global_active;
	assign FWD_VALID      = fwd_valid;
	assign FWD_ADDR       = fwd_addr;
	assign FWD_WRITE      = fwd_write;
	assign FWD_POSTED     = fwd_posted;
	assign LOAD_DONE      = (ld_state == LD_DONE);
endmodule // bridge_device

// [rtl/bridge_host.sv]
// host end: reset sequencing, configuration master, lock and arbiter
module bridge_host #(
	parameter int HOLD_WAIT = bridge_pkg::HOLD_WAIT_CYCLES,
	parameter int PRIM_LAG  = bridge_pkg::PRIM_LAG_CYCLES
) (
	// clock and reset
	input  wire logic                 CLK,
	input  wire logic                 ARST_N,
	// primary link
	bridge_link.host                  LINK,
	// software port
	input  wire logic [8:0]           ADDR,
	input  wire logic [31:0]          WDATA,
	input  wire logic                 WRITE,
	input  wire logic                 READ,
	output logic [31:0]               RDATA,
	// transaction source
	input  wire logic                 TXN_VALID,
	input  wire logic [31:0]          TXN_ADDR,
	input  wire logic                 TXN_WRITE,
	output logic                      TXN_RETRY,
	// arbiter
	input  wire logic [1:0]           MASTER_REQ,
	input  wire logic                 WRITEBACK_REQ,
	output logic [1:0]                MASTER_GNT,
	output logic                      WRITEBACK_GNT
);
	import bridge_pkg::*;

	typedef enum {RS_HOLD, RS_GLOBAL, RS_RUN} rst_t;

	////////////////////////////////////////////////////////////////////////
	// reset sequencer
	rst_t        rs, next_rs;
	logic [15:0] cnt, next_cnt;
	logic [31:0] ctrl, next_ctrl;
	logic [31:0] hrdata, next_hrdata;
	logic        local_sel;

	assign local_sel = ADDR[HOST_LOCAL_BIT];

	always_comb begin
		next_rs   = rs;
		next_cnt  = cnt + 16'h0001;
		case (rs)
			RS_HOLD: begin
				// clock counted stable for 100 us before global release
				if (cnt == 16'(HOLD_WAIT - 1)) begin
					next_rs  = RS_GLOBAL;
					next_cnt = 16'h0000;
				end
			end
			RS_GLOBAL: begin
				// primary reset never leaves before global
				if (cnt == 16'(PRIM_LAG - 1)) begin
					next_rs  = RS_RUN;
					next_cnt = 16'h0000;
				end
			end
			RS_RUN: next_cnt = 16'h0000;
			default: next_rs = RS_HOLD;
		endcase
		next_ctrl = ctrl;
		if (WRITE && local_sel && ADDR == HOST_CTRL) begin
			next_ctrl = WDATA;
		end
		next_hrdata = 32'h0000_0000;
		if (READ && local_sel) begin
			if (ADDR == HOST_CTRL) begin
				next_hrdata = ctrl;
			end else if (ADDR == HOST_STATUS) begin
				next_hrdata = {28'h0, !LINK.inta_n, LINK.post_enable,
					rs == RS_RUN, rs != RS_HOLD};
			end
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rs     <= RS_HOLD;
			cnt    <= 16'h0000;
			ctrl   <= 32'h0000_0000;
			hrdata <= 32'h0000_0000;
		end else begin
			rs     <= next_rs;
			cnt    <= next_cnt;
			ctrl   <= next_ctrl;
			hrdata <= next_hrdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link drive; both resets held low from power-up
	assign LINK.global_reset_n      = (rs != RS_HOLD);
	assign LINK.primary_bus_reset_n = (rs == RS_RUN);
	assign LINK.suspend             = ctrl[CTRL_SUSPEND_BIT];
	assign LINK.cfg_addr            = ADDR[7:0];
	assign LINK.cfg_wdata           = WDATA;
	assign LINK.cfg_write           = WRITE && !local_sel;
	assign LINK.cfg_read            = READ && !local_sel;
	assign LINK.txn_valid           = TXN_VALID;
	assign LINK.txn_addr            = TXN_ADDR;
	assign LINK.txn_write           = TXN_WRITE;
	// lock is its own protocol: master 0 owns it through the control bit
	assign LINK.lock_n              = !ctrl[CTRL_LOCK_BIT];
	assign TXN_RETRY                = LINK.txn_retry;
	// both sources read zero outside their answer cycle
	assign RDATA                    = hrdata | LINK.cfg_rdata;

	////////////////////////////////////////////////////////////////////////
	// complete-lock arbiter: owner only, except a snoop writeback
	always_comb begin
		WRITEBACK_GNT = WRITEBACK_REQ;
		MASTER_GNT    = 2'h0;
		if (!WRITEBACK_REQ) begin
			if (ctrl[CTRL_LOCK_BIT]) begin
				MASTER_GNT[0] = MASTER_REQ[0];
			end else if (MASTER_REQ[0]) begin
				MASTER_GNT[0] = 1'b1;
			end else begin
				MASTER_GNT[1] = MASTER_REQ[1];
			end
		end
	end
endmodule // bridge_host

// [sim/bridge_checker.sv]
// concurrent checks on the link that joins the host end to the device end
module bridge_checker #(
	parameter int HOLD_WAIT = 8
) (
	// clock and reset
	input wire logic        CLK,
	input wire logic        ARST_N,
	// link signals
	input wire logic        global_reset_n,
	input wire logic        primary_bus_reset_n,
	input wire logic        suspend,
	input wire logic        txn_valid,
	input wire logic [31:0] txn_addr,
	input wire logic        lock_n,
	input wire logic        txn_retry,
	input wire logic        post_enable,
	input wire logic        inta_oe_n
);
	timeunit 1ns;
	timeprecision 1ns;
	// host may count one edge less than we do at the release edge
	localparam int HOLD_MIN = HOLD_WAIT - 1;
	logic [10:0] low_cnt;
	logic [27:0] lock_region;
	logic        core_run;
	assign core_run = global_reset_n && (primary_bus_reset_n || suspend);
	////////////////////////////////////////////////////////////////
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			low_cnt <= '0;
			lock_region <= '0;
		end else begin
			if (global_reset_n)
				low_cnt <= '0;
			else if (low_cnt != 11'h7ff)
				low_cnt <= low_cnt + 11'h001;
			if (txn_valid && !lock_n && post_enable && core_run)
				lock_region <= txn_addr[31:4];
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	oe_in_reset_a: assert property (!global_reset_n |-> inta_oe_n)
		else $error("interrupt driven during global reset");
	reset_order_a: assert property (!global_reset_n |-> !primary_bus_reset_n)
		else $error("primary reset released before global reset");
	hold_wait_a: assert property ($rose(global_reset_n) |-> int'(low_cnt) >= HOLD_MIN)
		else $error("global reset released too early");
	lock_nopost_a: assert property (txn_valid && !lock_n && post_enable && core_run
		|=> !post_enable) else $error("posting left on after lock taken");
	lock_hold_a: assert property (!post_enable && !lock_n |=> !post_enable)
		else $error("lock dropped while lock line held");
	lock_retry_a: assert property (txn_valid && lock_n && !post_enable
		&& txn_addr[31:4] == lock_region |-> txn_retry) else $error("locked region not retried");
	open_region_a: assert property (txn_valid && (!lock_n
		|| txn_addr[31:4] != lock_region) |-> !txn_retry) else $error("open access retried");
	lock_release_a: assert property (!post_enable && lock_n && !txn_valid && core_run
		|=> post_enable) else $error("lock not released");
	core_reset_a: assert property (!primary_bus_reset_n && !suspend
		|-> ##[1:2] post_enable) else $error("core kept lock through primary reset");
endmodule // bridge_checker

// [sim/tb_pci_side_lock_and_subsys_id.sv]
// self-checking bench joining the host and device ends of the bridge link
module tb_pci_side_lock_and_subsys_id import bridge_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int          HOLD_W  = 8;
	localparam logic [31:0] EE_WORD = 32'h5a3c_c3a5;
	localparam logic [31:0] LK_ADDR = 32'h1000_0008;
	localparam logic [31:0] MF_SEL  = {12'h000, MF_LOCK_SEL, 16'h0000};
	typedef struct packed {
		logic        w;
		logic [8:0]  a;
		logic [31:0] d;
	} row_t;
	// writes carry data, reads carry the expected answer
	localparam row_t ROWS [17] = '{
		'{1'b0, {1'b0, SUBSYS_VENDOR}, EE_WORD}, '{1'b0, {1'b0, SYS_CTRL}, SYS_CTRL_RESET},
		'{1'b0, {1'b0, MF_ROUTING}, MF_ROUTING_RESET}, '{1'b1, {1'b0, SUBSYS_VENDOR}, 32'h1111_2222},
		'{1'b0, {1'b0, SUBSYS_VENDOR}, EE_WORD}, '{1'b1, {1'b0, SYS_CTRL}, 32'h0000_0000},
		'{1'b1, {1'b0, SUBSYS_VENDOR}, 32'h1111_2222}, '{1'b0, {1'b0, SUBSYS_VENDOR}, 32'h1111_2222},
		'{1'b1, {1'b0, SYS_CTRL}, SYS_CTRL_RESET}, '{1'b1, {1'b0, SUBSYS_VENDOR}, 32'h3333_4444},
		'{1'b0, {1'b0, SUBSYS_VENDOR}, 32'h1111_2222}, '{1'b0, 9'h0f0, 32'h0000_0000},
		'{1'b0, 9'h1f0, 32'h0000_0000}, '{1'b1, {1'b0, MF_ROUTING}, MF_SEL},
		'{1'b0, {1'b0, MF_ROUTING}, MF_SEL}, '{1'b0, HOST_STATUS, 32'h0000_0007},
		'{1'b0, {1'b0, BRIDGE_STATUS}, 32'h0000_0002}};
	logic        CLK = 1'b0, ARST_N = 1'b0, WRITE = 1'b0, READ = 1'b0;
	logic [8:0]  ADDR = '0;
	logic [31:0] WDATA = '0, TXN_ADDR = '0, RDATA, FWD_ADDR;
	logic        TXN_VALID = 1'b0, TXN_WRITE = 1'b0, WRITEBACK_REQ = 1'b0, CARD_IRQ_N = 1'b1;
	logic [1:0]  MASTER_REQ = '0, MASTER_GNT;
	logic        TXN_RETRY, WRITEBACK_GNT, MULTIPURPOSE_PIN_FOUR, MULTIPURPOSE_PIN_FOUR_OE_N;
	logic        CARD_LOCK_N, CARD_LOCK_OE_N, EE_SCL, EE_SCL_OE_N, EE_SDA_IN;
	logic        FWD_VALID, FWD_WRITE, FWD_POSTED, LOAD_DONE;
	logic [5:0]  ee_idx = '0;
	int          err_count = 0, compares = 0, n;
	always #50 CLK = ~CLK;
	////////////////////////////////////////////////////////////////
	bridge_link bridge_link_inst ();
	// a lag of 8 leaves room to set suspend and write before primary release
	bridge_host #(.HOLD_WAIT(HOLD_W), .PRIM_LAG(8)) bridge_host_inst (.CLK(CLK), .ARST_N(ARST_N),
		.LINK(bridge_link_inst), .ADDR(ADDR), .WDATA(WDATA), .WRITE(WRITE), .READ(READ),
		.RDATA(RDATA), .TXN_VALID(TXN_VALID), .TXN_ADDR(TXN_ADDR), .TXN_WRITE(TXN_WRITE),
		.TXN_RETRY(TXN_RETRY), .MASTER_REQ(MASTER_REQ), .WRITEBACK_REQ(WRITEBACK_REQ),
		.MASTER_GNT(MASTER_GNT), .WRITEBACK_GNT(WRITEBACK_GNT));
	bridge_device bridge_device_inst (.CLK(CLK), .ARST_N(ARST_N), .LINK(bridge_link_inst),
		.MULTIPURPOSE_PIN_FOUR(MULTIPURPOSE_PIN_FOUR),
		.MULTIPURPOSE_PIN_FOUR_OE_N(MULTIPURPOSE_PIN_FOUR_OE_N), .CARD_LOCK_N(CARD_LOCK_N),
		.CARD_LOCK_OE_N(CARD_LOCK_OE_N), .EE_SCL(EE_SCL), .EE_SCL_OE_N(EE_SCL_OE_N),
		.EE_SDA_IN(EE_SDA_IN), .CARD_IRQ_N(CARD_IRQ_N), .FWD_VALID(FWD_VALID),
		.FWD_ADDR(FWD_ADDR), .FWD_WRITE(FWD_WRITE), .FWD_POSTED(FWD_POSTED),
		.LOAD_DONE(LOAD_DONE));
	bridge_checker #(.HOLD_WAIT(HOLD_W)) bridge_checker_inst (.CLK(CLK), .ARST_N(ARST_N),
		.global_reset_n(bridge_link_inst.global_reset_n),
		.primary_bus_reset_n(bridge_link_inst.primary_bus_reset_n),
		.suspend(bridge_link_inst.suspend), .txn_valid(bridge_link_inst.txn_valid),
		.txn_addr(bridge_link_inst.txn_addr), .lock_n(bridge_link_inst.lock_n),
		.txn_retry(bridge_link_inst.txn_retry), .post_enable(bridge_link_inst.post_enable),
		.inta_oe_n(bridge_link_inst.inta_oe_n));
	////////////////////////////////////////////////////////////////
	// eeprom word, msb first; a new bit at each scl rise, past the last bit a flipped level
	always @(posedge EE_SCL or negedge bridge_link_inst.primary_bus_reset_n) begin
		if (!bridge_link_inst.primary_bus_reset_n)
			ee_idx <= '0;
		else if (ee_idx != 6'h20)
			ee_idx <= ee_idx + 6'h01;
	end
	assign EE_SDA_IN = (ee_idx < 6'h20) ? EE_WORD[5'h1f - ee_idx[4:0]] : ~EE_WORD[0];
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic op(input logic w, input logic [8:0] a, input logic [31:0] d);
		@(posedge CLK);
		WRITE <= w;
		READ <= !w;
		ADDR <= a;
		WDATA <= d;
		@(posedge CLK);
		WRITE <= 1'b0;
		READ <= 1'b0;
		#1;
		if (!w)
			check(RDATA, d);
	endtask
	task automatic txn(input logic [31:0] a, input logic exp_retry, input logic exp_post);
		@(posedge CLK);
		TXN_VALID <= 1'b1;
		TXN_ADDR <= a;
		TXN_WRITE <= 1'b1;
		#1 check(TXN_RETRY, exp_retry);
		@(posedge CLK);
		TXN_VALID <= 1'b0;
		#1 check({FWD_VALID, FWD_WRITE, FWD_POSTED}, {!exp_retry, 1'b1, exp_post});
		check(FWD_ADDR, a);
	endtask
	task automatic wait_load();
		n = 0;
		while (LOAD_DONE !== 1'b1 && n < 2000) begin
			@(posedge CLK);
			n++;
		end
		check(LOAD_DONE, 1'b1);
	endtask
	task automatic end_of_test();
		$display("compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge CLK);
		err_count++;
		end_of_test();
	end
	initial begin
		repeat (6) @(posedge CLK);
		ARST_N <= 1'b1;
		#1 check(MULTIPURPOSE_PIN_FOUR_OE_N, 1'b1);
		wait_load();
		foreach (ROWS[i])
			op(ROWS[i].w, ROWS[i].a, ROWS[i].d);
		$display("test register rows done");
		op(1'b1, HOST_CTRL, 32'h0000_0002);
		txn(LK_ADDR, 1'b0, 1'b0);
		check({CARD_LOCK_N, CARD_LOCK_OE_N, MULTIPURPOSE_PIN_FOUR, MULTIPURPOSE_PIN_FOUR_OE_N},
			4'h0);
		@(posedge CLK);
		MASTER_REQ <= 2'b11;
		#1 check(MASTER_GNT, 2'b01);
		@(posedge CLK);
		MASTER_REQ <= 2'b10;
		#1 check(MASTER_GNT, 2'b00);
		@(posedge CLK);
		WRITEBACK_REQ <= 1'b1;
		#1 check(WRITEBACK_GNT, 1'b1);
		txn(LK_ADDR + 32'h20, 1'b0, 1'b0);
		// owner keeps its access up while the lock line is let go
		TXN_VALID <= 1'b1;
		TXN_ADDR <= LK_ADDR;
		op(1'b1, HOST_CTRL, 32'h0000_0000);
		check(TXN_RETRY, 1'b1);
		txn(LK_ADDR + 32'h10, 1'b0, 1'b0);
		txn(LK_ADDR + 32'h4, 1'b0, 1'b1);
		check(MULTIPURPOSE_PIN_FOUR, 1'b1);
		@(posedge CLK);
		MASTER_REQ <= 2'b10;
		WRITEBACK_REQ <= 1'b0;
		CARD_IRQ_N <= 1'b0;
		#1 check(MASTER_GNT, 2'b10);
		repeat (6) @(posedge CLK);
		#1 check(bridge_link_inst.inta_n, 1'b0);
		$display("test lock and interrupt done");
		op(1'b1, {1'b0, SYS_CTRL}, 32'h0000_0000);
		ARST_N <= 1'b0;
		#100 check({CARD_LOCK_OE_N, EE_SCL_OE_N, MULTIPURPOSE_PIN_FOUR_OE_N,
			bridge_link_inst.inta_n, bridge_link_inst.primary_bus_reset_n}, 5'h1e);
		@(posedge CLK);
		ARST_N <= 1'b1;
		n = 0;
		while (bridge_link_inst.global_reset_n !== 1'b1 && n < 100) begin
			@(posedge CLK);
			n++;
		end
		#1 check(n >= HOLD_W && n < 100, 1'b1);
		check(bridge_link_inst.primary_bus_reset_n, 1'b0);
		op(1'b0, {1'b0, SYS_CTRL}, SYS_CTRL_RESET);
		// suspend raised while primary reset is still low: the write must land
		op(1'b1, HOST_CTRL, 32'h0000_0001);
		op(1'b1, {1'b0, SYS_CTRL}, 32'h0000_0000);
		check(bridge_link_inst.primary_bus_reset_n, 1'b0);
		CARD_IRQ_N <= 1'b1;
		wait_load();
		op(1'b0, {1'b0, SUBSYS_VENDOR}, EE_WORD);
		op(1'b0, {1'b0, SYS_CTRL}, 32'h0000_0000);
		$display("test second reset done");
		end_of_test();
	end
endmodule // tb_pci_side_lock_and_subsys_id
